// ### hw/ccrsx_pkg.sv
// Constants, opcodes and register map of the system instruction executor
package ccrsx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_OPA     = 8'h04;
  localparam logic [7:0] ADDR_OPB     = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_SRC     = 8'h14;
  localparam logic [7:0] ADDR_DST     = 8'h18;
  localparam logic [7:0] ADDR_PC      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // Status fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_SLEEP   = 1;
  localparam int unsigned STAT_ILLEGAL = 2;
  localparam logic [7:0]  FLAGS_RESET  = 8'h80;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Condition code bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_C = 0;

  // ----------------------------------------------------------------
  // Primary opcodes (upper byte of the first word)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_SLEEP      = 8'h01;
  localparam logic [7:0] OP_FLG_STORE  = 8'h02;
  localparam logic [7:0] OP_FLG_LOAD_R = 8'h03;
  localparam logic [7:0] OP_FLG_OR     = 8'h04;
  localparam logic [7:0] OP_FLG_XOR    = 8'h05;
  localparam logic [7:0] OP_FLG_AND    = 8'h06;
  localparam logic [7:0] OP_FLG_LOAD_I = 8'h07;
  localparam logic [7:0] OP_ADD_W      = 8'h09;
  localparam logic [7:0] OP_ADDX       = 8'h0E;
  localparam logic [7:0] OP_DAA        = 8'h0F;
  localparam logic [7:0] OP_SUB_W      = 8'h19;
  localparam logic [7:0] OP_SUBX       = 8'h1E;
  localparam logic [7:0] OP_DIVXU      = 8'h51;
  localparam logic [7:0] OP_MOVE       = 8'h7B;

  // ----------------------------------------------------------------
  // State counts
  // ----------------------------------------------------------------
  localparam logic [3:0] SHORT_STATES     = 4'h2;
  localparam logic [3:0] MOVE_BASE_STATES = 4'h9;
  localparam logic [3:0] MOVE_BASE_LOW    = 4'h8;
  localparam logic [1:0] MOVE_BYTE_LAST   = 2'h3;
  localparam logic [15:0] PC_STEP_SHORT   = 16'h0002;
  localparam logic [15:0] PC_STEP_MOVE    = 16'h0004;

  typedef enum logic [2:0] {
    ALU_NONE, ALU_ADDW, ALU_SUBW, ALU_ADDX, ALU_SUBX, ALU_DAA, ALU_DIVXU
  } ccrsx_alu_e;

endpackage

// ### hw/ccrsx_flags.sv
// Arithmetic result and special flag rules for the executor
`timescale 1ns/1ps
module ccrsx_flags (
  // Operation select
  input  wire ccrsx_pkg::ccrsx_alu_e kind,
  // Operands and current flags
  input  wire logic [15:0]           op_a,
  input  wire logic [15:0]           op_b,
  input  wire logic [7:0]            flags_in,
  // Results
  output logic      [15:0]           result,
  output logic      [7:0]            flags_out
);

  logic [16:0] wide;
  logic [12:0] low12;
  logic [8:0]  byte9;
  logic [4:0]  nib5;
  logic [8:0]  adj;
  logic        adj_c;

  always_comb begin
    wide    = 17'h00000;
    low12   = 13'h0000;
    byte9   = 9'h000;
    nib5    = 5'h00;
    adj     = 9'h000;
    adj_c   = 1'b0;
    result    = op_a;
    flags_out = flags_in;
    case (kind)
      ccrsx_pkg::ALU_ADDW, ccrsx_pkg::ALU_SUBW: begin
        if (kind == ccrsx_pkg::ALU_ADDW) begin
          wide  = {1'b0, op_a} + {1'b0, op_b};
          low12 = {1'b0, op_a[11:0]} + {1'b0, op_b[11:0]};
          flags_out[ccrsx_pkg::FLAG_V] = (op_a[15] == op_b[15]) && (wide[15] != op_a[15]);
        end else begin
          wide  = {1'b0, op_a} - {1'b0, op_b};
          low12 = {1'b0, op_a[11:0]} - {1'b0, op_b[11:0]};
          flags_out[ccrsx_pkg::FLAG_V] = (op_a[15] != op_b[15]) && (wide[15] != op_a[15]);
        end
        result = wide[15:0];
        flags_out[ccrsx_pkg::FLAG_H] = low12[12];
        flags_out[ccrsx_pkg::FLAG_N] = wide[15];
        flags_out[ccrsx_pkg::FLAG_Z] = (wide[15:0] == 16'h0000);
        flags_out[ccrsx_pkg::FLAG_C] = wide[16];
      end
      ccrsx_pkg::ALU_ADDX, ccrsx_pkg::ALU_SUBX: begin
        if (kind == ccrsx_pkg::ALU_ADDX) begin
          byte9 = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]} + {8'h00, flags_in[ccrsx_pkg::FLAG_C]};
          nib5  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, flags_in[ccrsx_pkg::FLAG_C]};
          flags_out[ccrsx_pkg::FLAG_V] = (op_a[7] == op_b[7]) && (byte9[7] != op_a[7]);
        end else begin
          byte9 = {1'b0, op_a[7:0]} - {1'b0, op_b[7:0]} - {8'h00, flags_in[ccrsx_pkg::FLAG_C]};
          nib5  = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, flags_in[ccrsx_pkg::FLAG_C]};
          flags_out[ccrsx_pkg::FLAG_V] = (op_a[7] != op_b[7]) && (byte9[7] != op_a[7]);
        end
        result = {op_a[15:8], byte9[7:0]};
        flags_out[ccrsx_pkg::FLAG_H] = nib5[4];
        flags_out[ccrsx_pkg::FLAG_N] = byte9[7];
        // Zero only ever survives, so multi-byte chains test the whole value
        flags_out[ccrsx_pkg::FLAG_Z] = (byte9[7:0] == 8'h00) ?
                                       flags_in[ccrsx_pkg::FLAG_Z] : 1'b0;
        flags_out[ccrsx_pkg::FLAG_C] = byte9[8];
      end
      ccrsx_pkg::ALU_DAA: begin
        adj = {1'b0, op_a[7:0]};
        if (op_a[3:0] > 4'h9 || flags_in[ccrsx_pkg::FLAG_H]) begin
          adj = adj + 9'h006;
        end
        if (op_a[7:0] > 8'h99 || flags_in[ccrsx_pkg::FLAG_C]) begin
          adj   = adj + 9'h060;
          adj_c = 1'b1;
        end
        result = {op_a[15:8], adj[7:0]};
        flags_out[ccrsx_pkg::FLAG_N] = adj[7];
        flags_out[ccrsx_pkg::FLAG_Z] = (adj[7:0] == 8'h00);
        if (adj_c) begin
          flags_out[ccrsx_pkg::FLAG_C] = 1'b1;
        end
      end
      ccrsx_pkg::ALU_DIVXU: begin
        if (op_b[7:0] != 8'h00) begin
          result = {8'(op_a % {8'h00, op_b[7:0]}), 8'(op_a / {8'h00, op_b[7:0]})};
        end
        flags_out[ccrsx_pkg::FLAG_N] = op_b[7];
        flags_out[ccrsx_pkg::FLAG_Z] = (op_b[7:0] == 8'h00);
      end
      default: begin
        result    = op_a;
        flags_out = flags_in;
      end
    endcase
  end

endmodule

// ### hw/ccrsx_exec.sv
// System instruction executor: power-down, block move, flag register ops
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
// Function
// - The power-down instruction enters low-power mode in 2 states and leaves every flag.
// - Block move copies bytes source to destination, bumping both pointers, until count is 0.
// - In the lower-cost variant the block move takes 4n + 8 states instead of 4n + 9.
// - Word add and subtract set half-carry on a carry or borrow at bit 11, else clear it.
// - Extended add and subtract keep zero on a zero result and clear it otherwise.
// - Decimal adjust sets carry when the adjustment carries and otherwise keeps it.
// - Unsigned divide sets negative when the divisor is negative, else clears it.
// - Unsigned divide sets zero when the divisor is zero, else clears it.
// - The primary opcode is bits 15 to 8 of the first instruction word.
module ccrsx_exec #(
  parameter bit LOW_COST = 1'b0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Data memory port
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic [7:0]  mem_rdata,
  // Status
  output logic             busy,
  output logic             low_power
);

  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_MOVE_PRE, ST_MOVE} ccrsx_state_e;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccrsx_state_e         state_reg;
  logic [15:0]          instr_reg;
  logic [15:0]          opa_reg;
  logic [15:0]          opb_reg;
  logic [7:0]           condition_code_reg;
  logic [7:0]           move_count_reg;
  logic [15:0]          move_source_ptr;
  logic [15:0]          move_dest_ptr;
  logic [15:0]          pc_reg;
  logic [3:0]           wait_reg;
  logic [1:0]           phase_reg;
  logic [7:0]           move_byte_reg;
  logic                 sleep_reg;
  logic                 illegal_reg;
  logic [15:0]          rdata_reg;
  ccrsx_pkg::ccrsx_alu_e alu_kind;
  logic [15:0]          alu_result;
  logic [7:0]           alu_flags;
  logic [7:0]           opcode;
  logic [7:0]           imm;
  logic                 idle;
  logic                 start;
  logic                 finish;
  logic                 legal;
  logic                 move_done;
  logic [3:0]           move_base;

  assign opcode    = instr_reg[15:8];
  assign imm       = instr_reg[7:0];
  assign idle      = (state_reg == ST_IDLE);
  assign start     = idle && !sleep_reg && reg_wr && (reg_addr == ccrsx_pkg::ADDR_INSTR);
  assign finish    = (state_reg == ST_EXEC) && (wait_reg == 4'h0);
  assign move_done = (state_reg == ST_MOVE) && (phase_reg == ccrsx_pkg::MOVE_BYTE_LAST);
  assign move_base = LOW_COST ? ccrsx_pkg::MOVE_BASE_LOW
                              : ccrsx_pkg::MOVE_BASE_STATES;

  assign busy      = !idle;
  assign low_power = sleep_reg;
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    alu_kind = ccrsx_pkg::ALU_NONE;
    legal    = 1'b1;
    case (opcode)
      ccrsx_pkg::OP_ADD_W: alu_kind = ccrsx_pkg::ALU_ADDW;
      ccrsx_pkg::OP_SUB_W: alu_kind = ccrsx_pkg::ALU_SUBW;
      ccrsx_pkg::OP_ADDX:  alu_kind = ccrsx_pkg::ALU_ADDX;
      ccrsx_pkg::OP_SUBX:  alu_kind = ccrsx_pkg::ALU_SUBX;
      ccrsx_pkg::OP_DAA:   alu_kind = ccrsx_pkg::ALU_DAA;
      ccrsx_pkg::OP_DIVXU: alu_kind = ccrsx_pkg::ALU_DIVXU;
      ccrsx_pkg::OP_NOP, ccrsx_pkg::OP_SLEEP, ccrsx_pkg::OP_FLG_STORE,
      ccrsx_pkg::OP_FLG_LOAD_R, ccrsx_pkg::OP_FLG_LOAD_I, ccrsx_pkg::OP_FLG_AND,
      ccrsx_pkg::OP_FLG_OR, ccrsx_pkg::OP_FLG_XOR, ccrsx_pkg::OP_MOVE: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  ccrsx_flags u_flags (
    .kind      (alu_kind),
    .op_a      (opa_reg),
    .op_b      (opb_reg),
    .flags_in  (condition_code_reg),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      wait_reg  <= 4'h0;
      phase_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= 2'h0;
          if (start) begin
            if (reg_wdata[15:8] == ccrsx_pkg::OP_MOVE) begin
              state_reg <= ST_MOVE_PRE;
              wait_reg  <= move_base - 4'h1;
            end else begin
              state_reg <= ST_EXEC;
              wait_reg  <= ccrsx_pkg::SHORT_STATES - 4'h1;
            end
          end
        end
        ST_EXEC: begin
          wait_reg <= wait_reg - 4'h1;
          if (finish) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_MOVE_PRE: begin
          wait_reg <= wait_reg - 4'h1;
          if (wait_reg == 4'h0) begin
            // A zero count ends here, after the fixed overhead only
            state_reg <= (move_count_reg == 8'h00) ? ST_IDLE : ST_MOVE;
          end
        end
        ST_MOVE: begin
          phase_reg <= phase_reg + 2'h1;
          if (move_done && move_count_reg == 8'h01) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Block move data path: read, capture, write, step
  // ----------------------------------------------------------------
  assign mem_rd    = (state_reg == ST_MOVE) && (phase_reg == 2'h0);
  assign mem_wr    = (state_reg == ST_MOVE) && (phase_reg == 2'h2);
  assign mem_addr  = (phase_reg[1]) ? move_dest_ptr : move_source_ptr;
  assign mem_wdata = move_byte_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      move_byte_reg <= 8'h00;
    end else if (state_reg == ST_MOVE && phase_reg == 2'h1) begin
      move_byte_reg <= mem_rdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      move_count_reg  <= 8'h00;
      move_source_ptr <= ccrsx_pkg::WORD_RESET;
      move_dest_ptr   <= ccrsx_pkg::WORD_RESET;
    end else if (move_done) begin
      move_source_ptr <= move_source_ptr + 16'h0001;
      move_dest_ptr   <= move_dest_ptr + 16'h0001;
      move_count_reg  <= move_count_reg - 8'h01;
    end else if (idle && reg_wr) begin
      if (reg_addr == ccrsx_pkg::ADDR_COUNT) begin
        move_count_reg <= reg_wdata[7:0];
      end else if (reg_addr == ccrsx_pkg::ADDR_SRC) begin
        move_source_ptr <= reg_wdata;
      end else if (reg_addr == ccrsx_pkg::ADDR_DST) begin
        move_dest_ptr <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction, operands and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_reg <= ccrsx_pkg::WORD_RESET;
      opa_reg   <= ccrsx_pkg::WORD_RESET;
      opb_reg   <= ccrsx_pkg::WORD_RESET;
    end else if (finish) begin
      if (alu_kind != ccrsx_pkg::ALU_NONE) begin
        opa_reg <= alu_result;
      end else if (opcode == ccrsx_pkg::OP_FLG_STORE) begin
        opa_reg <= {opa_reg[15:8], condition_code_reg};
      end
    end else if (start) begin
      instr_reg <= reg_wdata;
    end else if (idle && reg_wr) begin
      if (reg_addr == ccrsx_pkg::ADDR_OPA) begin
        opa_reg <= reg_wdata;
      end else if (reg_addr == ccrsx_pkg::ADDR_OPB) begin
        opb_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= ccrsx_pkg::WORD_RESET;
    end else if (finish) begin
      pc_reg <= pc_reg + ccrsx_pkg::PC_STEP_SHORT;
    end else if (state_reg == ST_MOVE_PRE && wait_reg == 4'h0 && move_count_reg == 8'h00) begin
      pc_reg <= pc_reg + ccrsx_pkg::PC_STEP_MOVE;
    end else if (move_done && move_count_reg == 8'h01) begin
      pc_reg <= pc_reg + ccrsx_pkg::PC_STEP_MOVE;
    end else if (idle && reg_wr && reg_addr == ccrsx_pkg::ADDR_PC) begin
      pc_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Condition code register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      condition_code_reg <= ccrsx_pkg::FLAGS_RESET;
    end else if (finish) begin
      // Power-down, store and no-operation fall through and leave flags
      if (alu_kind != ccrsx_pkg::ALU_NONE) begin
        condition_code_reg <= alu_flags;
      end else if (opcode == ccrsx_pkg::OP_FLG_LOAD_I) begin
        condition_code_reg <= imm;
      end else if (opcode == ccrsx_pkg::OP_FLG_LOAD_R) begin
        condition_code_reg <= opa_reg[7:0];
      end else if (opcode == ccrsx_pkg::OP_FLG_AND) begin
        condition_code_reg <= condition_code_reg & imm;
      end else if (opcode == ccrsx_pkg::OP_FLG_OR) begin
        condition_code_reg <= condition_code_reg | imm;
      end else if (opcode == ccrsx_pkg::OP_FLG_XOR) begin
        condition_code_reg <= condition_code_reg ^ imm;
      end
    end else if (idle && reg_wr && reg_addr == ccrsx_pkg::ADDR_FLAGS) begin
      condition_code_reg <= reg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Power-down and illegal flags; completion wins over a clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sleep_reg   <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (finish && opcode == ccrsx_pkg::OP_SLEEP) begin
        sleep_reg <= 1'b1;
      end else if (reg_wr && reg_addr == ccrsx_pkg::ADDR_STATUS &&
                   reg_wdata[ccrsx_pkg::STAT_SLEEP]) begin
        sleep_reg <= 1'b0;
      end
      if (finish && !legal) begin
        illegal_reg <= 1'b1;
      end else if (reg_wr && reg_addr == ccrsx_pkg::ADDR_STATUS &&
                   reg_wdata[ccrsx_pkg::STAT_ILLEGAL]) begin
        illegal_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == ccrsx_pkg::ADDR_INSTR) begin
        rdata_reg <= instr_reg;
      end else if (reg_addr == ccrsx_pkg::ADDR_OPA) begin
        rdata_reg <= opa_reg;
      end else if (reg_addr == ccrsx_pkg::ADDR_OPB) begin
        rdata_reg <= opb_reg;
      end else if (reg_addr == ccrsx_pkg::ADDR_FLAGS) begin
        rdata_reg <= {8'h00, condition_code_reg};
      end else if (reg_addr == ccrsx_pkg::ADDR_COUNT) begin
        rdata_reg <= {8'h00, move_count_reg};
      end else if (reg_addr == ccrsx_pkg::ADDR_SRC) begin
        rdata_reg <= move_source_ptr;
      end else if (reg_addr == ccrsx_pkg::ADDR_DST) begin
        rdata_reg <= move_dest_ptr;
      end else if (reg_addr == ccrsx_pkg::ADDR_PC) begin
        rdata_reg <= pc_reg;
      end else if (reg_addr == ccrsx_pkg::ADDR_STATUS) begin
        rdata_reg <= {13'h0000, illegal_reg, sleep_reg, !idle};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

endmodule

// ### tb/ccrsx_props.sv
// Port-level checker for the system instruction executor
`timescale 1ns/1ps
module ccrsx_props #(
  parameter bit LOW_COST = 1'b0
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Memory port
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_rdata,
  // Status
  input wire logic        busy,
  input wire logic        low_power
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic issue;
  assign issue = reg_wr && reg_addr == ccrsx_pkg::ADDR_INSTR && !busy && !low_power;

  property p_short_len;
    issue && reg_wdata[15:8] != ccrsx_pkg::OP_MOVE |=> busy ##1 busy ##1 !busy;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short op length");
  property p_sleep_in;
    issue && reg_wdata[15:8] == ccrsx_pkg::OP_SLEEP |=> ##2 low_power;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no power-down");
  property p_sleep_idle;
    low_power && !reg_wr |=> low_power && !busy;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep left");
  property p_move_min;
    issue && reg_wdata[15:8] == ccrsx_pkg::OP_MOVE |=> busy [*8];
  endproperty
  a_move_min: assert property (p_move_min) else $error("move too short");
  property p_rd_wr;
    mem_rd |=> !mem_rd && !mem_wr ##1 mem_wr;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("byte phase order");
  property p_wdata;
    mem_rd ##1 1'b1 |=> mem_wdata == $past(mem_rdata);
  endproperty
  a_wdata: assert property (p_wdata) else $error("copied byte wrong");
  property p_addr_step;
    mem_rd ##4 mem_rd |-> mem_addr == $past(mem_addr, 4) + 16'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("source step");
  property p_mem_busy;
    mem_rd || mem_wr |-> busy;
  endproperty
  a_mem_busy: assert property (p_mem_busy) else $error("access while idle");
endmodule

bind ccrsx_exec ccrsx_props #(.LOW_COST(LOW_COST)) u_props (
  .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
  .busy(busy), .low_power(low_power)
);

// ### tb/ccrsx_mem_model.sv
// Byte memory model answering the executor's data port
`timescale 1ns/1ps
module ccrsx_mem_model (
  // Clock
  input  wire logic        clock,
  // Access
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [256];
  initial begin
    mem_rdata = 8'h00;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
  end
  // Data valid only the cycle after a read, toggling otherwise
  always @(posedge clock) begin
    mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
    if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the system instruction executor
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] rdata, m_addr, m_addr_l, d;
  logic [7:0]  m_wd, m_wd_l, m_rdat, m_rdat_l;
  logic        m_rd, m_rd_l, m_wr, m_wr_l, busy, busy_l, lp, lp_l;
  int          fail_count = 0;
  int          checks = 0;
  logic [63:0] at [13] = '{64'h0008000800092020, 64'h0000010001092000, 64'h0010000001192020,
    64'h04000000000E0404, 64'h00000000000E0400, 64'h04000100000E0400, 64'h04000500051E0404,
    64'h01001200000F0101, 64'h00001200000F0100, 64'h00009A00000F0105, 64'h0000100080510C08,
    64'h0000100000510C04, 64'h0800100004510C00};
  logic [15:0] fi [4] = '{16'h0712, 16'h0441, 16'h0503, 16'h061F};
  logic [7:0]  fc [4] = '{8'h12, 8'h53, 8'h50, 8'h10};

  always #5 clock = ~clock;
  ccrsx_exec #(.LOW_COST(1'b0)) dut_u (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .mem_addr(m_addr), .mem_wdata(m_wd), .mem_rd(m_rd), .mem_wr(m_wr), .mem_rdata(m_rdat),
    .busy(busy), .low_power(lp));
  ccrsx_exec #(.LOW_COST(1'b1)) dut_l (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .mem_addr(m_addr_l), .mem_wdata(m_wd_l), .mem_rd(m_rd_l), .mem_wr(m_wr_l),
    .mem_rdata(m_rdat_l), .busy(busy_l), .low_power(lp_l));
  ccrsx_mem_model mem_u (.clock(clock), .mem_addr(m_addr), .mem_wdata(m_wd), .mem_rd(m_rd),
    .mem_wr(m_wr), .mem_rdata(m_rdat));
  ccrsx_mem_model mem_l (.clock(clock), .mem_addr(m_addr_l), .mem_wdata(m_wd_l),
    .mem_rd(m_rd_l), .mem_wr(m_wr_l), .mem_rdata(m_rdat_l));

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Issue one instruction and count busy states on both variants
  task automatic run(input logic [15:0] ins, input int len, input int len_l);
    int n, nl;
    n = 0;
    nl = 0;
    wr(ccrsx_pkg::ADDR_INSTR, ins);
    #1;
    while ((busy | busy_l) === 1'b1 && n < 2000) begin
      n += int'(busy);
      nl += int'(busy_l);
      @(posedge clock);
      #1;
    end
    `CHK(n, len)
    `CHK(nl, len_l)
  endtask
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    chk(ccrsx_pkg::ADDR_FLAGS, {8'h00, ccrsx_pkg::FLAGS_RESET});
    chk(8'h24, 16'h0000);
    foreach (fi[i]) begin
      run(fi[i], 2, 2);
      chk(ccrsx_pkg::ADDR_FLAGS, {8'h00, fc[i]});
    end
    wr(ccrsx_pkg::ADDR_OPA, 16'h00A5);
    run(16'h0300, 2, 2);
    chk(ccrsx_pkg::ADDR_FLAGS, 16'h00A5);
    wr(ccrsx_pkg::ADDR_OPA, 16'h0000);
    run(16'h0200, 2, 2);
    chk(ccrsx_pkg::ADDR_OPA, 16'h00A5);
    $display("flag register test done");
    wr(ccrsx_pkg::ADDR_PC, 16'h0100);
    run(16'h00FF, 2, 2);
    chk(ccrsx_pkg::ADDR_PC, 16'h0102);
    chk(ccrsx_pkg::ADDR_FLAGS, 16'h00A5);
    run(16'h0100, 2, 2);
    `CHK(lp, 1'b1)
    chk(ccrsx_pkg::ADDR_FLAGS, 16'h00A5);
    run(16'h0712, 0, 0);
    wr(ccrsx_pkg::ADDR_STATUS, 16'h0002);
    chk(ccrsx_pkg::ADDR_STATUS, 16'h0000);
    run(16'h2200, 2, 2);
    chk(ccrsx_pkg::ADDR_STATUS, 16'h0004);
    wr(ccrsx_pkg::ADDR_STATUS, 16'h0004);
    $display("no-op and power-down test done");
    foreach (at[i]) begin
      run({ccrsx_pkg::OP_FLG_LOAD_I, at[i][63:56]}, 2, 2);
      wr(ccrsx_pkg::ADDR_OPA, at[i][55:40]);
      wr(ccrsx_pkg::ADDR_OPB, at[i][39:24]);
      run({at[i][23:16], 8'h00}, 2, 2);
      chk(ccrsx_pkg::ADDR_FLAGS, {8'h00, at[i][7:0]});
    end
    $display("special flag test done");
    wr(ccrsx_pkg::ADDR_COUNT, 16'h0000);
    run(16'h7B00, 9, 8);
    wr(ccrsx_pkg::ADDR_SRC, 16'h0010);
    wr(ccrsx_pkg::ADDR_DST, 16'h0080);
    wr(ccrsx_pkg::ADDR_COUNT, 16'h0003);
    run(16'h7B00, 21, 20);
    chk(ccrsx_pkg::ADDR_SRC, 16'h0013);
    chk(ccrsx_pkg::ADDR_DST, 16'h0083);
    chk(ccrsx_pkg::ADDR_COUNT, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      d[7:0] = (k < 3) ? (8'h10 + 8'(k)) ^ 8'h5A : 8'h83 ^ 8'h5A;
      `CHK(mem_u.mem[8'h80 + 8'(k)], d[7:0])
      `CHK(mem_l.mem[8'h80 + 8'(k)], d[7:0])
    end
    $display("block move test done");
    test_done();
  end
endmodule
